// >>> rtl/ivb_defs.svh
// constants for the interface vector bus processor and its port bank
// assumes a single clock; times are in ns
`ifndef IVB_DEFS_SVH
`define IVB_DEFS_SVH
`define IVB_CYCLE_NS 250
`define IVB_CLK_NS 100
// quarter of a cycle in clocks, rounded down, at least one
`define IVB_QUARTER_CYC (((`IVB_CYCLE_NS / 4) / `IVB_CLK_NS) > 0 ? ((`IVB_CYCLE_NS / 4) / `IVB_CLK_NS) : 1)
`define IVB_RESET_ADDR 13'h0000
`define IVB_AUX_IDX 3'h0
// instruction fields
`define IVB_F_OP 15:13
`define IVB_F_SK 12:11
`define IVB_F_SS 10:8
`define IVB_F_LEN 7:5
`define IVB_F_DK 4:3
`define IVB_F_DS 2:0
`define IVB_F_IMM 7:0
`define IVB_F_SHORT 4:0
`define IVB_F_JMP 12:0
// destination kinds; source kinds 2 and 3 are left and right bank
`define IVB_DK_REG 2'h0
`define IVB_DK_ADDR 2'h1
`define IVB_HALT_SLACK 2
`endif

// >>> rtl/ivb_pkg.sv
// types used by the processor end of the interface vector bus
// assumes ivb_defs.svh for the numeric constants
package ivb_pkg;
    typedef enum logic [4:0] {
        st_q1 = 5'h01,
        st_q2 = 5'h02,
        st_q3 = 5'h04,
        st_q4 = 5'h08,
        st_wait = 5'h10
    } ivb_state_t;
    typedef enum logic [2:0] {
        op_move = 3'h0,
        op_add = 3'h1,
        op_and = 3'h2,
        op_xor = 3'h3,
        op_xec = 3'h4,
        op_nzt = 3'h5,
        op_xmit = 3'h6,
        op_jmp = 3'h7
    } ivb_op_t;
endpackage : ivb_pkg

// >>> rtl/ivb_if.sv
// interface joining the processor end and the port/memory end
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface ivb_if;
    logic [12:0] program_address_lines;
    logic [15:0] instruction_input_lines;
    logic [7:0] dev_iv_out;
    logic dev_iv_oe;
    logic [7:0] left_port_out;
    logic left_port_oe;
    logic [7:0] right_port_out;
    logic right_port_oe;
    logic left_bank_enable;
    logic right_bank_enable;
    logic write_command;
    logic select_command;
    logic master_clock;
    logic halt_request;
    wire [7:0] io_bus_lines;
    // bus level; ports only drive in a read of their enabled bank
    assign io_bus_lines = dev_iv_oe ? dev_iv_out :
        (left_bank_enable & ~write_command & left_port_oe) ? left_port_out :
        (right_bank_enable & ~write_command & right_port_oe) ? right_port_out : 8'h00;
    modport cpu (
        output program_address_lines, dev_iv_out, dev_iv_oe, left_bank_enable, right_bank_enable,
        output write_command, select_command, master_clock,
        input instruction_input_lines, io_bus_lines, halt_request
    );
    modport ports (
        input program_address_lines, dev_iv_out, dev_iv_oe, left_bank_enable, right_bank_enable,
        input write_command, select_command, master_clock, io_bus_lines,
        output instruction_input_lines, halt_request, left_port_out, left_port_oe,
        output right_port_out, right_port_oe
    );
endinterface : ivb_if

// >>> rtl/ivb_cpu.sv
// processor end: fetch, four-quarter cycle, registers and bus control
// assumes the port end answers fetches and drives halt_request
// Contract
// (RULE1) halt holds processor in wait, no processing
// (RULE2) reset makes next fetch address zero
// (RULE3) counter increments, holds or loads per instruction
// (RULE4) address register drives 13-bit program address
// (RULE5) 16-bit instruction captured into instruction register
// (RULE6) address from counter, instruction or alu
// (RULE7) eight 8-bit registers; aux is second operand
// (RULE8) overflow bit captures each add's carry
// (RULE9) latch keeps input byte for output merge
// (RULE10) select command marks bus byte as address
// (RULE11) port enables itself only on own address
// (RULE12) processor alone sets direction via write command
// (RULE13) port responds only while its bank enabled
// (RULE14) bank is ninth address bit, changeable mid-instruction
// (RULE15) two active ports only on opposite banks
// (RULE16) one instruction cycle of four quarters
// (RULE17) next address in third quarter, instruction first
// (RULE18) input latched first quarter, alu second quarter
// (RULE19) output second half, master clock when stable
// (RULE20) input and output banks chosen independently
// (RULE21) next fetch overlaps current data operation
// (RULE22) halt and reset sampled at cycle boundary
`timescale 1ns/1ns
`include "ivb_defs.svh"
module ivb_cpu #(
    parameter int QCYC = `IVB_QUARTER_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reset_req,
    ivb_if.cpu bus,
    output logic [12:0] o_pc,
    output logic o_ovf,
    output logic o_waiting
);
    ivb_pkg::ivb_state_t state_q;
    ivb_pkg::ivb_state_t state_d;
    ivb_pkg::ivb_op_t op;
    logic wait_q;
    logic [7:0] qdiv_q;
    logic [15:0] ir_q;
    logic valid_q;
    logic [12:0] pc_q;
    logic [12:0] ar_q;
    logic [12:0] pc_d;
    logic [12:0] ar_d;
    logic [7:0] regs_q [0:7];
    logic [7:0] latch_q;
    logic [7:0] dout_q;
    logic [7:0] alu;
    logic ovf_q;
    logic lb_q;
    logic rb_q;
    logic wc_q;
    logic sc_q;
    logic mclk_q;
    logic doe_q;

    // quarter-cycle enable
    wire tick = (qdiv_q == 8'(QCYC - 1));
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            qdiv_q <= 8'h00;
        end else begin
            qdiv_q <= tick ? 8'h00 : qdiv_q + 8'h01;
        end
    end

    // current instruction fields
    assign op = ivb_pkg::ivb_op_t'(ir_q[`IVB_F_OP]);
    wire is_xmit = (op == ivb_pkg::op_xmit);
    wire is_data = (op[2] == 1'b0) | is_xmit;
    wire [1:0] sk = ir_q[`IVB_F_SK];
    wire [2:0] ss = ir_q[`IVB_F_SS];
    wire [2:0] len = ir_q[`IVB_F_LEN];
    wire [1:0] dk = is_xmit ? ir_q[`IVB_F_SK] : ir_q[`IVB_F_DK];
    wire [2:0] ds = is_xmit ? ir_q[`IVB_F_SS] : ir_q[`IVB_F_DS];

    // rotate, mask, alu against aux, shift and merge
    wire [7:0] src_raw = sk[1] ? latch_q : regs_q[ss];
    wire [7:0] src_rot = sk[1] ? ((src_raw >> ss) | (src_raw << (4'h8 - {1'b0, ss}))) : src_raw;
    // xmit carries a whole byte, so its low bits are not a length
    wire [7:0] mask = ((len == 3'h0) | is_xmit) ? 8'hff : 8'((9'h001 << len) - 9'h001);
    wire [7:0] opa = src_rot & mask;
    wire [7:0] opb = regs_q[`IVB_AUX_IDX] & mask; // RULE7
    wire [8:0] sum = {1'b0, opa} + {1'b0, opb};
    wire [3:0] cpos = (len == 3'h0) ? 4'h8 : {1'b0, len};
    wire add_ovf = sum[cpos];
    always_comb begin
        case (op)
            ivb_pkg::op_add: alu = sum[7:0] & mask;
            ivb_pkg::op_and: alu = opa & opb;
            ivb_pkg::op_xor: alu = opa ^ opb;
            ivb_pkg::op_xmit: alu = ir_q[`IVB_F_IMM];
            default: alu = opa;
        endcase
    end
    wire [7:0] mshift = mask << ds;
    wire [7:0] ashift = alu << ds;
    wire [7:0] merged = (latch_q & ~mshift) | (ashift & mshift); // RULE9
    wire writes_reg = valid_q & is_data & (dk == `IVB_DK_REG);
    wire drives_bus = valid_q & is_data & (dk != `IVB_DK_REG);
    wire is_addr = (dk == `IVB_DK_ADDR);
    wire out_right = is_addr ? ds[0] : dk[0]; // RULE20
    wire [7:0] bus_val = is_addr ? alu : merged;

    // next fetch address
    always_comb begin
        pc_d = pc_q + 13'h0001; // RULE3
        ar_d = pc_d;
        case (op)
            ivb_pkg::op_jmp: begin
                ar_d = ir_q[`IVB_F_JMP]; // RULE6
                pc_d = ar_d;
            end
            ivb_pkg::op_nzt: begin
                if (alu != 8'h00) begin
                    ar_d = {pc_q[12:5], ir_q[`IVB_F_SHORT]}; // RULE6
                    pc_d = ar_d;
                end
            end
            ivb_pkg::op_xec: begin
                ar_d = {pc_q[12:8], 8'(alu + {3'h0, ir_q[`IVB_F_SHORT]})}; // RULE6
                pc_d = pc_q; // RULE3
            end
            default: begin
            end
        endcase
    end

    // fetched word and its decode at the boundary
    wire [15:0] nxt = bus.instruction_input_lines;
    wire nxt_in = (nxt[15] == 1'b0 | nxt[`IVB_F_OP] == 3'h4 | nxt[`IVB_F_OP] == 3'h5) & nxt[12];
    wire at_edge = tick & (state_q == ivb_pkg::st_q4 | state_q == ivb_pkg::st_wait); // RULE22
    wire go = ~i_reset_req & ~bus.halt_request;
    wire q1 = tick & (state_q == ivb_pkg::st_q1);
    wire q2 = tick & (state_q == ivb_pkg::st_q2);
    wire q3 = tick & (state_q == ivb_pkg::st_q3);

    always_comb begin
        state_d = state_q;
        if (tick) begin
            case (state_q)
                ivb_pkg::st_q1: state_d = ivb_pkg::st_q2; // RULE16
                ivb_pkg::st_q2: state_d = ivb_pkg::st_q3;
                ivb_pkg::st_q3: state_d = ivb_pkg::st_q4;
                default: state_d = (bus.halt_request & ~i_reset_req) ? ivb_pkg::st_wait : ivb_pkg::st_q1; // RULE1
            endcase
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ivb_pkg::st_q1;
            wait_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wait_q <= (state_d == ivb_pkg::st_wait);
        end
    end

    // instruction capture; a reset cycle executes nothing
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ir_q <= 16'h0000;
            valid_q <= 1'b0;
        end else if (at_edge) begin
            valid_q <= go; // RULE1
            if (go) begin
                ir_q <= nxt; // RULE5 RULE17
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pc_q <= `IVB_RESET_ADDR;
            ar_q <= `IVB_RESET_ADDR;
        end else if (at_edge & i_reset_req) begin
            pc_q <= `IVB_RESET_ADDR; // RULE2
            ar_q <= `IVB_RESET_ADDR;
        end else if (q2 & valid_q) begin
            pc_q <= pc_d; // RULE3
            ar_q <= ar_d; // RULE21
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                regs_q[i] <= 8'h00;
            end
        end else if (q2 & writes_reg) begin
            regs_q[ds] <= alu; // RULE7
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovf_q <= 1'b0;
        end else if (q2 & valid_q & (op == ivb_pkg::op_add)) begin
            ovf_q <= add_ovf; // RULE8
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_q <= 8'h00;
        end else if (q1 & (lb_q | rb_q)) begin
            latch_q <= bus.io_bus_lines; // RULE18 RULE9
        end
    end

    // bank enables: input bank in first quarter, output bank in second half
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lb_q <= 1'b0;
            rb_q <= 1'b0;
        end else if (at_edge) begin
            lb_q <= go & nxt_in & ~nxt[11]; // RULE20
            rb_q <= go & nxt_in & nxt[11];
        end else if (q1) begin
            lb_q <= 1'b0;
            rb_q <= 1'b0;
        end else if (q2 & drives_bus) begin
            lb_q <= ~out_right; // RULE14 RULE15
            rb_q <= out_right;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wc_q <= 1'b0;
            sc_q <= 1'b0;
            doe_q <= 1'b0;
            dout_q <= 8'h00;
        end else if (at_edge) begin
            wc_q <= 1'b0;
            sc_q <= 1'b0;
            doe_q <= 1'b0;
        end else if (q2 & drives_bus) begin
            wc_q <= 1'b1; // RULE12
            sc_q <= is_addr; // RULE10
            doe_q <= 1'b1; // RULE19
            dout_q <= bus_val;
        end
    end

    // master clock in the last quarter, bus stable since third
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mclk_q <= 1'b0;
        end else if (q3) begin
            mclk_q <= doe_q; // RULE19
        end else if (at_edge) begin
            mclk_q <= 1'b0;
        end
    end

    assign bus.program_address_lines = ar_q; // RULE4
    assign bus.dev_iv_out = dout_q;
    assign bus.dev_iv_oe = doe_q;
    assign bus.left_bank_enable = lb_q;
    assign bus.right_bank_enable = rb_q;
    assign bus.write_command = wc_q;
    assign bus.select_command = sc_q;
    assign bus.master_clock = mclk_q;
    assign o_pc = pc_q;
    assign o_ovf = ovf_q;
    assign o_waiting = wait_q;
endmodule : ivb_cpu

// >>> rtl/ivb_ioport.sv
// port end: program memory, two banks of addressable ports, write fifo
// assumes the processor end on the same clock through ivb_if
`timescale 1ns/1ns
`include "ivb_defs.svh"
module ivb_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_valid,
    input wire logic [W-1:0] i_data,
    output logic o_ready,
    output logic o_valid,
    output logic [W-1:0] o_data,
    input wire logic i_ready,
    output logic [$clog2(D):0] o_level
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] FULL = (AW + 1)'(D);
    logic [W-1:0] mem_q [0:D-1];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = i_valid & o_ready;
    wire pop = o_valid & i_ready;
    assign o_ready = (cnt_q != FULL);
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rp_q];
    assign o_level = cnt_q;
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem_q[wp_q] <= i_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= push ? wp_q + 1'b1 : wp_q;
            rp_q <= pop ? rp_q + 1'b1 : rp_q;
            cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
        end
    end
endmodule : ivb_fifo

module ivb_ioport #(
    parameter int NPORT = 4,
    parameter int DEPTH = 32,
    parameter logic [16*NPORT-1:0] PORT_ADDRS = 64'h13121110_03020100
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    ivb_if.ports bus,
    input wire logic i_halt,
    input wire logic i_prog_we,
    input wire logic [12:0] i_prog_addr,
    input wire logic [15:0] i_prog_data,
    output logic o_out_valid,
    output logic [((NPORT > 1) ? $clog2(NPORT) : 1)+8:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int IW = (NPORT > 1) ? $clog2(NPORT) : 1;
    localparam int OW = IW + 9;
    localparam int LW = $clog2(DEPTH) + 1;
    logic [15:0] prog_q [0:8191];
    logic [15:0] instr_q;
    logic [7:0] stor_q [0:2*NPORT-1];
    logic [2*NPORT-1:0] hit;
    logic [IW-1:0] hidx [0:1];
    logic [1:0] hany;
    logic [1:0] sel_q;
    logic [IW-1:0] sidx_q [0:1];
    logic [1:0] sel_d;
    logic [IW-1:0] sidx_d [0:1];
    logic [7:0] out_q [0:1];
    logic [1:0] oe_q;
    logic halt_q;
    logic fifo_ready;
    logic [LW-1:0] level;

    always_ff @(posedge i_clk) begin
        if (i_prog_we) begin
            prog_q[i_prog_addr] <= i_prog_data;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            instr_q <= 16'h0000;
        end else begin
            instr_q <= prog_q[bus.program_address_lines]; // RULE17
        end
    end

    // address compare per port
    for (genvar k = 0; k < 2 * NPORT; k++) begin : g_cmp
        assign hit[k] = (bus.io_bus_lines == PORT_ADDRS[8*k +: 8]); // RULE11
    end
    always_comb begin
        hany = 2'b00;
        hidx[0] = '0;
        hidx[1] = '0;
        for (int b = 0; b < 2; b++) begin
            for (int p = 0; p < NPORT; p++) begin
                if (hit[b*NPORT+p]) begin
                    hany[b] = 1'b1;
                    hidx[b] = IW'(p);
                end
            end
        end
    end

    wire [1:0] ben = {bus.right_bank_enable, bus.left_bank_enable};
    wire strobe = bus.master_clock & bus.write_command;
    wire wbank = bus.right_bank_enable;
    wire wr_ok = strobe & ~bus.select_command & |(ben & sel_q); // RULE13
    wire [OW-1:0] push_word = {wbank, sidx_q[wbank], bus.io_bus_lines};

    // next selection, so a port picked at the boundary drives in the next first quarter
    always_comb begin
        sel_d = sel_q;
        sidx_d[0] = sidx_q[0];
        sidx_d[1] = sidx_q[1];
        for (int b = 0; b < 2; b++) begin
            if (strobe & bus.select_command & ben[b]) begin
                sel_d[b] = hany[b]; // RULE11 RULE13 RULE14
                sidx_d[b] = hidx[b];
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sel_q <= 2'b00;
            sidx_q[0] <= '0;
            sidx_q[1] <= '0;
        end else begin
            sel_q <= sel_d;
            sidx_q[0] <= sidx_d[0];
            sidx_q[1] <= sidx_d[1];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int k = 0; k < 2 * NPORT; k++) begin
                stor_q[k] <= 8'h00;
            end
        end else if (wr_ok) begin
            stor_q[(wbank ? NPORT : 0) + int'(sidx_q[wbank])] <= bus.io_bus_lines; // RULE19
        end
    end

    // one selected port per bank presents its byte
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            oe_q <= 2'b00;
            out_q[0] <= 8'h00;
            out_q[1] <= 8'h00;
        end else begin
            for (int b = 0; b < 2; b++) begin
                oe_q[b] <= sel_d[b]; // RULE15
                // a byte written at the boundary is readable in the next first quarter
                if (wr_ok & (wbank == 1'(b))) begin
                    out_q[b] <= bus.io_bus_lines;
                end else begin
                    out_q[b] <= stor_q[b*NPORT + int'(sidx_d[b])];
                end
            end
        end
    end

    // halt the processor before the fifo can overflow
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            halt_q <= 1'b0;
        end else begin
            halt_q <= i_halt | ~fifo_ready | (level >= LW'(DEPTH - `IVB_HALT_SLACK)); // RULE1
        end
    end

    ivb_fifo #(
        .W(OW),
        .D(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_valid(wr_ok),
        .i_data(push_word),
        .o_ready(fifo_ready),
        .o_valid(o_out_valid),
        .o_data(o_out_data),
        .i_ready(i_out_ready),
        .o_level(level)
    );

    // a write when full is dropped; halt keeps this from happening
    assign bus.instruction_input_lines = instr_q;
    assign bus.halt_request = halt_q;
    assign bus.left_port_out = out_q[0];
    assign bus.left_port_oe = oe_q[0];
    assign bus.right_port_out = out_q[1];
    assign bus.right_port_oe = oe_q[1];
endmodule : ivb_ioport

// >>> sim/ivb_bus_checker.sv
// concurrent checks on the bus signals shared by the processor end and the port end
// assumes one clock and an active-low asynchronous reset, quarter of one clock
`timescale 1ns/1ns
module ivb_bus_checker (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [12:0] program_address_lines,
    input wire logic [7:0] dev_iv_out,
    input wire logic dev_iv_oe,
    input wire logic left_bank_enable,
    input wire logic right_bank_enable,
    input wire logic write_command,
    input wire logic select_command,
    input wire logic master_clock,
    input wire logic halt_request,
    input wire logic o_waiting
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    wire any_bank = left_bank_enable | right_bank_enable;
    // output half: drive first, one strobe, then release at the boundary
    sequence out_drive_s;
        write_command && dev_iv_oe && !master_clock;
    endsequence
    sequence out_strobe_s;
        master_clock && write_command ##1 !master_clock && !write_command;
    endsequence
    // input quarter: bank opened for reading only, closed a quarter later
    sequence in_phase_s;
        any_bank && !write_command && !dev_iv_oe ##1 !any_bank;
    endsequence
    out_phase_a: assert property ($rose(write_command) |-> out_drive_s ##1 out_strobe_s)
        else $error("output phase out of order");
    in_phase_a: assert property (any_bank && !write_command |-> in_phase_s)
        else $error("input phase malformed");
    mclk_cause_a: assert property (master_clock |-> dev_iv_oe && $stable(dev_iv_out) && $past(dev_iv_oe)
        && (left_bank_enable != right_bank_enable))
        else $error("strobe without stable driven bus");
    sel_write_a: assert property (select_command |-> write_command && dev_iv_oe)
        else $error("address flag outside a write");
    bank_excl_a: assert property (!(left_bank_enable && right_bank_enable))
        else $error("both banks enabled at once");
    wait_quiet_a: assert property (o_waiting |-> !dev_iv_oe && !any_bank && !master_clock)
        else $error("bus activity while waiting");
    halt_enter_a: assert property (halt_request [*6] |-> o_waiting)
        else $error("halt not taken at boundary");
    wait_hold_a: assert property (o_waiting |-> $stable(program_address_lines))
        else $error("fetch address moved while waiting");
endmodule : ivb_bus_checker

// >>> sim/interface_vector_bus_cycle_tb.sv
// self-checking bench: processor end and port end joined by the bus interface
// assumes default port addresses, left 00..03 and right 10..13, and fifo depth 32
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); n_mismatch++; end end
module interface_vector_bus_cycle_tb;
    logic i_clk, i_rst_n, i_reset_req, i_halt, i_prog_we, i_out_ready;
    logic [12:0] i_prog_addr, o_pc;
    logic [15:0] i_prog_data;
    logic o_ovf, o_waiting, o_out_valid;
    logic [10:0] o_out_data;
    logic [7:0] ra, rb, rc;
    logic [15:0] prog [12];
    logic [8:0] sum;
    int n_mismatch = 0, n_compared = 0, n_pop = 0, pop_base = 0, cycles = 0, k;
    ivb_if ivb_if_i ();
    ivb_cpu ivb_cpu_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset_req(i_reset_req), .bus(ivb_if_i),
        .o_pc(o_pc), .o_ovf(o_ovf), .o_waiting(o_waiting));
    ivb_ioport ivb_ioport_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .bus(ivb_if_i), .i_halt(i_halt),
        .i_prog_we(i_prog_we), .i_prog_addr(i_prog_addr), .i_prog_data(i_prog_data),
        .o_out_valid(o_out_valid), .o_out_data(o_out_data), .i_out_ready(i_out_ready));
    ivb_bus_checker ivb_bus_checker_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .program_address_lines(ivb_if_i.program_address_lines), .dev_iv_out(ivb_if_i.dev_iv_out),
        .dev_iv_oe(ivb_if_i.dev_iv_oe), .left_bank_enable(ivb_if_i.left_bank_enable),
        .right_bank_enable(ivb_if_i.right_bank_enable), .write_command(ivb_if_i.write_command),
        .select_command(ivb_if_i.select_command), .master_clock(ivb_if_i.master_clock),
        .halt_request(ivb_if_i.halt_request), .o_waiting(o_waiting));
    // pop order: left port 1, copy to right port 1, xor left, and right, then the sum forever
    function automatic logic [10:0] exp_word(input int n);
        if (n == 0) return {3'h1, ra};
        if (n == 1) return {3'h5, ra};
        if (n == 2) return {3'h1, rb ^ rc};
        if (n == 3) return {3'h5, rb & rc};
        return {3'h1, sum[7:0]};
    endfunction : exp_word
    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #10;
    endtask : step
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cycles++;
        if (i_rst_n && o_out_valid === 1'b1 && i_out_ready) begin
            `CHK(o_out_data, exp_word(n_pop - pop_base))
            n_pop++;
        end
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    initial begin
        void'($urandom(40496));
        {i_rst_n, i_reset_req, i_halt, i_prog_we, i_out_ready} = 5'h00;
        i_prog_addr = 13'h0000;
        i_prog_data = 16'h0000;
        ra = 8'($urandom);
        // top bits set so the add always overflows
        rb = 8'($urandom) | 8'h80;
        rc = 8'($urandom) | 8'h80;
        sum = 9'(rb) + 9'(rc);
        // nzt at 8 skips the trap write at 9; add and jump loop at 10 and 11
        prog = '{16'hc801, 16'hc911, {8'hd0, ra}, 16'h1018, {8'hc0, rb}, {8'hc1, rc}, 16'h6110, 16'h4118,
            16'ha10a, 16'hd0ff, 16'h2110, 16'he00a};
        step(1);
        for (int i = 0; i < 12; i++) begin
            i_prog_we = 1'b1;
            i_prog_addr = 13'(i);
            i_prog_data = prog[i];
            step(1);
        end
        i_prog_we = 1'b0;
        i_rst_n = 1'b1;
        // fill the fifo with the consumer stalled until the processor halts
        k = 0;
        while (o_waiting !== 1'b1 && k < 1000) begin
            step(1);
            k++;
        end
        `CHK(o_waiting, 1'b1)
        `CHK(o_ovf, sum[8])
        `CHK(o_pc[12:1], 12'h005)
        step(20);
        `CHK(o_waiting, 1'b1)
        repeat (300) begin
            i_out_ready = 1'($urandom);
            step(1);
        end
        i_halt = 1'b1;
        k = 0;
        while (o_waiting !== 1'b1 && k < 40) begin
            step(1);
            k++;
        end
        i_out_ready = 1'b1;
        step(40);
        `CHK(o_out_valid, 1'b0)
        `CHK(o_waiting, 1'b1)
        i_halt = 1'b0;
        k = 0;
        while (o_waiting !== 1'b0 && k < 40) begin
            step(1);
            k++;
        end
        `CHK(o_waiting, 1'b0)
        step(8);
        i_reset_req = 1'b1;
        step(6);
        pop_base = n_pop;
        `CHK(o_pc, 13'h0000)
        step(2);
        i_reset_req = 1'b0;
        step(60);
        `CHK(n_pop - pop_base > 2, 1'b1)
        `CHK(o_ovf, sum[8])
        print_verdict();
    end
endmodule : interface_vector_bus_cycle_tb
